// File: src/pbqc_pkg.sv
package pbqc_pkg;
  // system timing
  localparam int CLK_MHZ = 10;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int PRN_SETUP_NS = 500;
  localparam int PRN_SETUP_CYC = (PRN_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRN_WIDTH_NS = 500;
  localparam int PRN_WIDTH_CYC = (PRN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int JC_W = 4;
  localparam int REG_AW = 2;

  // johnson counter
  localparam logic [JC_W-1:0] JC_RESET = 4'h0;

  // register port map
  localparam logic [REG_AW-1:0] REG_STATUS = 2'h0;
  localparam logic [REG_AW-1:0] REG_CTRL = 2'h1;

  // status register fields
  localparam int ST_READY_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_EMPTY_BIT = 2;
  localparam int ST_STROBE_BIT = 3;
  localparam int ST_HELD_BIT = 4;
  localparam int ST_BUSY_BIT = 5;

  // control register fields
  localparam int CTRL_PRINT_EN_BIT = 0;
  localparam logic CTRL_PRINT_EN_RESET = 1'b1;

  // reset values
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] PTR_ONE = 16'h0001;
endpackage

// File: src/pbqc_top.sv
`timescale 1ns/10ps
// Operation
// - one 10 MHz clock; all timing counted in 100 ns states.
// - four-stage johnson counter gives eight states, decoded from adjacent bits.
// - memory alternates four write states and four read states without pause.
// - write strobe low only in states one and two of a requested write slot.
// - ram data sampled at end of state six; read byte held flag sets.
// - host byte captured on rising edge of write pulse; loaded flag drops ready.
// - synchronizer sets next edge; byte moves to stage only when stage empty.
// - after the move loaded flag then synchronizer clear; ready returns.
// - write request sets on edge before write slot, only when not full.
// - requested write slot drives stage byte on ram data, select low.
// - end of requested write slot clears request and advances store pointer.
// - read slot flag sets end of state three, clears end of state seven.
// - read slot clears the edge after byte held; read pointer advances.
// - strobe begin sets at next state three, five states after data valid.
// - strobe end sets at state zero, five states after strobe begin.
// - printer strobe active while begin set and end still clear.
// - acknowledge low clears strobe begin.
// - after an acknowledge, ack and busy both inactive clear byte held and strobe end.
// - read slot cannot set while byte held remains set.
// - empty when pointers equal, full when next store equals read.
// - two separate 16-bit pointers multiplexed onto one address bus.
// - memory select combines write slot select and read slot select.
// - master reset clears every flip-flop of the controller except write pulse history and print enable, which it sets.
module pbqc_top
  import pbqc_pkg::*;
(
  input wire logic clk, // 10 MHz system clock
  input wire logic reset_n, // master reset, synchronous
  input wire logic [DATA_W-1:0] host_data_pins, // host write data
  input wire logic host_wr_n, // host write pulse
  output logic host_ready, // capture register can take a byte
  output logic buffer_full, // queue full
  output logic buffer_empty, // queue empty
  input wire logic [REG_AW-1:0] reg_addr, // register address
  input wire logic [DATA_W-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
  output logic [ADDR_W-1:0] mem_addr, // ram address
  input wire logic [DATA_W-1:0] mem_data_in, // ram data pins, input side
  output logic [DATA_W-1:0] mem_data_out, // ram data pins, output side
  output logic mem_data_oe, // ram data pins driven
  output logic mem_select_n, // ram chip select
  output logic mem_write_strobe_n, // ram write enable
  output logic [DATA_W-1:0] printer_data_pins, // printer data
  output logic printer_strobe_n, // printer data strobe
  input wire logic printer_ack_n, // printer acknowledge
  input wire logic printer_busy // printer busy
);

  typedef struct packed {
    logic [JC_W-1:0] jc;
    logic host_wr_n_prev;
    logic [DATA_W-1:0] capture;
    logic host_byte_loaded;
    logic load_synchronizer;
    logic [DATA_W-1:0] stage;
    logic stage_valid;
    logic mem_write_request;
    logic [ADDR_W-1:0] store_ptr;
    logic [ADDR_W-1:0] read_ptr;
    logic read_slot_active;
    logic read_byte_held;
    logic [DATA_W-1:0] readback;
    logic strobe_begin;
    logic strobe_end;
    logic ack_seen;
    logic [ADDR_W-1:0] addr;
    logic print_en;
    logic [DATA_W-1:0] rdata;
  } pbqc_st_s;

  localparam pbqc_st_s ST_RESET = '{
    jc: JC_RESET,
    host_wr_n_prev: 1'b1,
    capture: DATA_RESET,
    host_byte_loaded: 1'b0,
    load_synchronizer: 1'b0,
    stage: DATA_RESET,
    stage_valid: 1'b0,
    mem_write_request: 1'b0,
    store_ptr: PTR_RESET,
    read_ptr: PTR_RESET,
    read_slot_active: 1'b0,
    read_byte_held: 1'b0,
    readback: DATA_RESET,
    strobe_begin: 1'b0,
    strobe_end: 1'b0,
    ack_seen: 1'b0,
    addr: PTR_RESET,
    print_en: CTRL_PRINT_EN_RESET,
    rdata: DATA_RESET
  };

  pbqc_st_s st_ff;
  pbqc_st_s nxt_st;

  logic state_zero, state_one, state_two, state_three;
  logic state_four, state_five, state_six, state_seven;
  logic write_phase, write_slot_select, read_slot_select;
  logic [ADDR_W-1:0] store_next;
  logic host_wr_rise, stage_move;

  // each state is decoded from two neighbouring counter bits, so only one
  // input of each gate changes per edge and the decodes cannot glitch
  assign state_zero = ~st_ff.jc[3] & ~st_ff.jc[0];
  assign state_one = st_ff.jc[3] & ~st_ff.jc[2];
  assign state_two = st_ff.jc[2] & ~st_ff.jc[1];
  assign state_three = st_ff.jc[1] & ~st_ff.jc[0];
  assign state_four = st_ff.jc[3] & st_ff.jc[0];
  assign state_five = ~st_ff.jc[3] & st_ff.jc[2];
  assign state_six = ~st_ff.jc[2] & st_ff.jc[1];
  assign state_seven = ~st_ff.jc[1] & st_ff.jc[0];
  assign write_phase = ~st_ff.jc[0];

  assign store_next = st_ff.store_ptr + PTR_ONE;
  assign buffer_empty = st_ff.read_ptr == st_ff.store_ptr;
  assign buffer_full = store_next == st_ff.read_ptr;
  assign host_ready = ~(st_ff.host_byte_loaded | st_ff.load_synchronizer);
  assign host_wr_rise = ~st_ff.host_wr_n_prev & host_wr_n;
  assign stage_move = st_ff.load_synchronizer & st_ff.host_byte_loaded & ~st_ff.stage_valid;

  assign write_slot_select = st_ff.mem_write_request & write_phase;
  assign read_slot_select = st_ff.read_slot_active;
  assign mem_select_n = ~(write_slot_select | read_slot_select);
  // states one and two are 1000 and 1100: bits three and one alone decide
  assign mem_write_strobe_n = ~(write_slot_select & st_ff.jc[3] & ~st_ff.jc[1]);
  assign mem_data_out = st_ff.stage;
  assign mem_data_oe = write_slot_select;
  assign mem_addr = st_ff.addr;
  assign printer_data_pins = st_ff.readback;
  assign printer_strobe_n = ~(st_ff.strobe_begin & ~st_ff.strobe_end);
  assign reg_rdata = st_ff.rdata;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.jc = {~st_ff.jc[0], st_ff.jc[JC_W-1:1]};

    // host input stage
    nxt_st.host_wr_n_prev = host_wr_n;
    if (host_wr_rise) begin
      nxt_st.capture = host_data_pins;
    end
    // loaded flag: set wins over the clear from the stage move
    if (host_wr_rise) begin
      nxt_st.host_byte_loaded = 1'b1;
    end else if (stage_move) begin
      nxt_st.host_byte_loaded = 1'b0;
    end
    // synchronizer follows the loaded flag one edge late, so it clears after it
    nxt_st.load_synchronizer = st_ff.host_byte_loaded;
    if (stage_move) begin
      nxt_st.stage = st_ff.capture;
      nxt_st.stage_valid = 1'b1;
    end

    // write request taken only on the last read state so no slot starts late
    if (st_ff.mem_write_request & state_three) begin
      nxt_st.mem_write_request = 1'b0;
      nxt_st.store_ptr = store_next;
      nxt_st.stage_valid = 1'b0;
    end else if (state_seven & st_ff.stage_valid & ~buffer_full) begin
      nxt_st.mem_write_request = 1'b1;
    end

    // read side
    if (st_ff.read_slot_active & state_six) begin
      nxt_st.readback = mem_data_in;
      nxt_st.read_byte_held = 1'b1;
    end
    if (st_ff.read_slot_active & st_ff.read_byte_held) begin
      nxt_st.read_slot_active = 1'b0;
      nxt_st.read_ptr = st_ff.read_ptr + PTR_ONE;
    end else if (state_seven) begin
      nxt_st.read_slot_active = 1'b0;
    end else if (state_three & ~buffer_empty & ~st_ff.read_byte_held & st_ff.print_en) begin
      nxt_st.read_slot_active = 1'b1;
    end

    // printer handshake
    if (~printer_ack_n) begin
      nxt_st.strobe_begin = 1'b0;
    end else if (state_three & st_ff.read_byte_held & ~st_ff.strobe_begin
                 & ~st_ff.strobe_end & ~st_ff.ack_seen) begin
      nxt_st.strobe_begin = 1'b1;
    end
    if (state_zero & st_ff.strobe_begin & ~st_ff.strobe_end) begin
      nxt_st.strobe_end = 1'b1;
    end
    if (~printer_ack_n & st_ff.read_byte_held) begin
      nxt_st.ack_seen = 1'b1;
    end
    // release needs an answer first, else the idle lines would drop the byte
    if (st_ff.ack_seen & printer_ack_n & ~printer_busy) begin
      nxt_st.read_byte_held = 1'b0;
      nxt_st.strobe_end = 1'b0;
      nxt_st.ack_seen = 1'b0;
    end

    // address follows the slot that the next state belongs to
    nxt_st.addr = ~nxt_st.jc[0] ? nxt_st.store_ptr : nxt_st.read_ptr;

    // register port
    if (reg_wr && reg_addr == REG_CTRL) begin
      nxt_st.print_en = reg_wdata[CTRL_PRINT_EN_BIT];
    end
    nxt_st.rdata = DATA_RESET;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: begin
          nxt_st.rdata[ST_READY_BIT] = host_ready;
          nxt_st.rdata[ST_FULL_BIT] = buffer_full;
          nxt_st.rdata[ST_EMPTY_BIT] = buffer_empty;
          nxt_st.rdata[ST_STROBE_BIT] = ~printer_strobe_n;
          nxt_st.rdata[ST_HELD_BIT] = st_ff.read_byte_held;
          nxt_st.rdata[ST_BUSY_BIT] = printer_busy;
        end
        REG_CTRL: begin
          nxt_st.rdata[CTRL_PRINT_EN_BIT] = st_ff.print_en;
        end
        default: begin
          nxt_st.rdata = DATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence strobe_rise_s;
    $rose(st_ff.strobe_begin) ##1 (st_ff.strobe_begin && printer_ack_n)[*4];
  endsequence

  sequence held_rise_s;
    $rose(st_ff.read_byte_held) ##1 (printer_ack_n)[*4];
  endsequence

  johnson_cycle_a: assert property (state_zero |=> (!state_zero)[*7] ##1 state_zero)
    else $error("timing states do not repeat every eight clocks");

  phase_split_a: assert property (state_four |-> !write_phase ##0 $past(write_phase, 4))
    else $error("write and read slots are not four states each");

  wstrobe_window_a: assert property (!mem_write_strobe_n |->
      (state_one || state_two) && !mem_select_n && mem_data_oe)
    else $error("ram write strobe outside states one and two");

  wreq_start_a: assert property ($rose(st_ff.mem_write_request) |->
      state_zero && $past(st_ff.stage_valid) && !$past(buffer_full))
    else $error("write request not raised just before a write slot");

  wreq_end_a: assert property (st_ff.mem_write_request && state_three |=>
      !st_ff.mem_write_request && st_ff.store_ptr == $past(store_next))
    else $error("write slot did not end with store pointer advance");

  readback_cap_a: assert property (st_ff.read_slot_active && state_six |=>
      st_ff.read_byte_held && printer_data_pins == $past(mem_data_in))
    else $error("ram data not sampled at end of state six");

  read_slot_start_a: assert property ($rose(st_ff.read_slot_active) |->
      state_four && !$past(st_ff.read_byte_held) && !$past(buffer_empty))
    else $error("read slot started at the wrong time");

  read_advance_a: assert property (st_ff.read_slot_active && st_ff.read_byte_held |=>
      !st_ff.read_slot_active && st_ff.read_ptr == $past(st_ff.read_ptr) + PTR_ONE)
    else $error("read slot did not end with read pointer advance");

  strobe_setup_a: assert property (held_rise_s |=> $rose(st_ff.strobe_begin))
    else $error("printer strobe not five states after data valid");

  strobe_width_a: assert property (strobe_rise_s |=> st_ff.strobe_end && printer_strobe_n)
    else $error("printer strobe not ended after five states");

  ack_clear_a: assert property (!printer_ack_n |=> !st_ff.strobe_begin)
    else $error("acknowledge did not clear strobe begin");

  load_wait_a: assert property (st_ff.load_synchronizer && st_ff.host_byte_loaded
      && st_ff.stage_valid && !st_ff.mem_write_request |=> st_ff.host_byte_loaded)
    else $error("captured byte did not wait for the stage register");

  load_chain_a: assert property ($rose(st_ff.host_byte_loaded) |=>
      st_ff.load_synchronizer && !host_ready)
    else $error("synchronizer did not follow the loaded flag");

  // reset is checked with the default disable switched off, else it could never fire
  reset_state_a: assert property (disable iff (1'b0) !reset_n |=>
      host_ready && buffer_empty && printer_strobe_n && mem_select_n && state_zero)
    else $error("controller not idle after master reset");

  wstrobe_slot_a: assert property (write_slot_select && (state_one || state_two) |->
      !mem_write_strobe_n)
    else $error("ram write strobe missing in a requested write slot");

  // address is registered from the next state, so it must already match the slot
  addr_select_a: assert property (mem_addr ==
      (write_phase ? st_ff.store_ptr : st_ff.read_ptr))
    else $error("ram address does not follow the slot phase");

  read_slot_end_a: assert property (st_ff.read_slot_active && state_seven |=>
      !st_ff.read_slot_active)
    else $error("read slot flag still set after state seven");

  read_nonempty_a: assert property (st_ff.read_slot_active |->
      !buffer_empty)
    else $error("read slot open on an empty queue");

  byte_release_a: assert property (st_ff.ack_seen && printer_ack_n && !printer_busy |=>
      !st_ff.read_byte_held && !st_ff.strobe_end)
    else $error("byte not released after printer went idle");

  strobe_data_a: assert property (!printer_strobe_n |->
      $stable(printer_data_pins))
    else $error("printer data changed under the strobe");

  sequence stage_move_s;
    st_ff.load_synchronizer && st_ff.host_byte_loaded && !st_ff.stage_valid;
  endsequence

  stage_move_a: assert property (stage_move_s |=>
      st_ff.stage_valid && st_ff.stage == $past(st_ff.capture) && !st_ff.host_byte_loaded)
    else $error("captured byte did not move into the empty stage");

  ready_return_a: assert property ($fell(st_ff.host_byte_loaded) |=>
      host_ready)
    else $error("ready did not return after the byte moved");

  // register reads answer for one cycle only, so a stale status cannot be seen twice
  rdata_idle_a: assert property (!reg_rd |=>
      reg_rdata == DATA_RESET)
    else $error("read data not cleared outside a read");

endmodule

// File: verif/pbqc_far_model.sv
`timescale 1ns/10ps
module pbqc_far_model
  import pbqc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic [ADDR_W-1:0] mem_addr, // ram address
  input wire logic [DATA_W-1:0] mem_data_out, // controller side of ram data pins
  input wire logic mem_data_oe, // controller drives ram data pins
  input wire logic mem_select_n, // ram select
  input wire logic mem_write_strobe_n, // ram write enable
  output logic [DATA_W-1:0] mem_data_in, // resolved ram data pins
  input wire logic printer_strobe_n, // printer strobe
  output logic printer_ack_n, // printer acknowledge
  output logic printer_busy, // printer busy
  input wire logic [31:0] ack_dly, // cycles from strobe to acknowledge, at least 1
  input wire logic [31:0] busy_len // cycles busy stays up after acknowledge
);
  logic [DATA_W-1:0] ram [0:65535];
  logic [DATA_W-1:0] last_bus;
  logic ram_drv;

  assign ram_drv = !mem_select_n && mem_write_strobe_n && !mem_data_oe;
  // floating pins toggle so a stale byte can never pass for a fresh read
  assign mem_data_in = mem_data_oe ? mem_data_out : (ram_drv ? ram[mem_addr] : ~last_bus);

  initial last_bus = 8'h00;

  always @(posedge clk) begin
    if (!mem_select_n && !mem_write_strobe_n) begin
      ram[mem_addr] <= mem_data_out;
    end
    last_bus <= mem_data_in;
  end

  initial begin
    printer_ack_n = 1'b1;
    printer_busy = 1'b0;
    forever begin
      @(negedge printer_strobe_n);
      repeat (ack_dly) @(posedge clk);
      printer_busy <= 1'b1;
      printer_ack_n <= 1'b0;
      repeat (2) @(posedge clk);
      printer_ack_n <= 1'b1;
      repeat (busy_len) @(posedge clk);
      printer_busy <= 1'b0;
    end
  end
endmodule

// File: verif/test_print_buffer_queue_controller.sv
`timescale 1ns/10ps
module test_print_buffer_queue_controller
  import pbqc_pkg::*;
;
  logic clk, reset_n, host_wr_n, reg_wr, reg_rd, mem_data_oe, mem_select_n, mem_write_strobe_n;
  logic host_ready, buffer_full, buffer_empty, printer_strobe_n, printer_ack_n, printer_busy;
  logic [DATA_W-1:0] host_data_pins, reg_wdata, reg_rdata, mem_data_in, mem_data_out;
  logic [DATA_W-1:0] printer_data_pins, cur_byte, st_idle;
  logic [REG_AW-1:0] reg_addr;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] exp_q[$];
  int miscompares = 0, cmp_count = 0, printed = 0, we_cnt = 0, st_cnt = 0, ack_dly, busy_len;
  logic slow;

  pbqc_top pbqc_top_i (.clk(clk), .reset_n(reset_n), .host_data_pins(host_data_pins),
    .host_wr_n(host_wr_n), .host_ready(host_ready), .buffer_full(buffer_full),
    .buffer_empty(buffer_empty), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_select_n(mem_select_n),
    .mem_write_strobe_n(mem_write_strobe_n), .printer_data_pins(printer_data_pins),
    .printer_strobe_n(printer_strobe_n), .printer_ack_n(printer_ack_n),
    .printer_busy(printer_busy));

  pbqc_far_model pbqc_far_model_i (.clk(clk), .mem_addr(mem_addr), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_select_n(mem_select_n),
    .mem_write_strobe_n(mem_write_strobe_n), .mem_data_in(mem_data_in),
    .printer_strobe_n(printer_strobe_n), .printer_ack_n(printer_ack_n),
    .printer_busy(printer_busy), .ack_dly(ack_dly), .busy_len(busy_len));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [REG_AW-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // host polls ready and full before every byte
  task automatic host_write(input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (host_ready !== 1'b1 || buffer_full !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 300) begin
        miscompares++;
        end_of_test();
      end
    end
    exp_q.push_back(d);
    @(posedge clk);
    host_wr_n <= 1'b0;
    host_data_pins <= d;
    @(posedge clk);
    host_wr_n <= 1'b1;
    @(posedge clk);
    #1;
    check("ready after host write", host_ready, 0);
  endtask

  task automatic wait_printed(input int n);
    int k;
    for (k = 0; k < 3000 && printed < n; k++) begin
      @(posedge clk);
    end
    if (printed < n) begin
      miscompares++;
      end_of_test();
    end
    check("bytes printed", printed, n);
  endtask

  // watchers on the ram and printer pins
  always @(posedge clk) begin
    if (reset_n === 1'b1) begin
      if (mem_write_strobe_n === 1'b0) begin
        check("select during write strobe", mem_select_n, 0);
        check("drive during write strobe", mem_data_oe, 1);
        we_cnt++;
      end else if (we_cnt != 0) begin
        check("write strobe width", we_cnt, 2);
        we_cnt = 0;
      end
      if (printer_strobe_n === 1'b0) begin
        if (st_cnt == 0) begin
          cur_byte = (exp_q.size() > 0) ? exp_q.pop_front() : ~printer_data_pins;
          printed++;
        end
        check("printer data", printer_data_pins, cur_byte);
        st_cnt++;
      end else if (st_cnt != 0) begin
        if (slow) check("strobe width", st_cnt, PRN_WIDTH_CYC);
        else check("strobe cut by ack", st_cnt < PRN_WIDTH_CYC, 1);
        st_cnt = 0;
      end
    end
  end

  initial begin
    logic [DATA_W-1:0] rd;
    int i;
    reset_n = 1'b0;
    host_wr_n = 1'b1;
    host_data_pins = 8'h00;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ack_dly = 7;
    busy_len = 4;
    slow = 1'b1;
    st_idle = 8'h00;
    st_idle[ST_READY_BIT] = 1'b1;
    st_idle[ST_EMPTY_BIT] = 1'b1;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check("ready", host_ready, 1);
    check("empty", buffer_empty, 1);
    check("full", buffer_full, 0);
    check("printer strobe", printer_strobe_n, 1);
    check("ram select", mem_select_n, 1);
    reg_read(REG_STATUS, rd);
    check("status", rd, st_idle);
    reg_read(REG_CTRL, rd);
    check("control", rd, CTRL_PRINT_EN_RESET);
    reg_write(REG_STATUS, 8'hff);
    reg_write(2'h2, 8'hff);
    reg_read(2'h2, rd);
    check("unmapped", rd, 0);
    reg_read(2'h3, rd);
    check("unmapped", rd, 0);
    reg_read(REG_STATUS, rd);
    check("status kept", rd, st_idle);
    // printing held off: bytes pile up in the ram queue
    reg_write(REG_CTRL, 8'h00);
    for (i = 0; i < 4; i++) host_write(8'ha0 + i[7:0]);
    repeat (64) @(posedge clk);
    check("held printed", printed, 0);
    check("not empty", buffer_empty, 0);
    reg_read(REG_STATUS, rd);
    check("status queued", rd, st_idle & ~(8'h01 << ST_EMPTY_BIT));
    reg_write(REG_CTRL, 8'h01);
    wait_printed(4);
    // let the last handshake finish before the printer timing changes
    repeat (40) @(posedge clk);
    // reset with bytes queued: none of them may be printed afterwards
    reg_write(REG_CTRL, 8'h00);
    host_write(8'h33);
    host_write(8'hcc);
    repeat (40) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    exp_q.delete();
    @(posedge clk);
    #1;
    check("empty after reset", buffer_empty, 1);
    check("ready after reset", host_ready, 1);
    reg_read(REG_CTRL, rd);
    check("control after reset", rd, CTRL_PRINT_EN_RESET);
    // fast acknowledge, busy only while acknowledge is low, edge data values
    slow = 1'b0;
    ack_dly = 1;
    busy_len = 0;
    host_write(8'h5a);
    host_write(8'ha5);
    host_write(8'hff);
    host_write(8'h00);
    wait_printed(8);
    repeat (20) @(posedge clk);
    check("empty at end", buffer_empty, 1);
    check("ready at end", host_ready, 1);
    end_of_test();
  end
endmodule
